// *** inc/scs_pkg.sv ***
`default_nettype none
package scs_pkg;
  // ----------------------------------------
  // Register offsets (printed offsets are indices)
  // ----------------------------------------
  localparam logic [7:0] IDX_GLOBAL = 8'h05;
  localparam logic [7:0] IDX_STATUS = 8'h06;
  localparam logic [7:0] IDX_ADC    = 8'h10;
  localparam logic [7:0] IDX_COL    = 8'h11;
  localparam logic [7:0] IDX_SENSE  = 8'h20;
  localparam logic [7:0] IDX_GAIN   = 8'h21;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SUB_A_LO   = 4;
  localparam int SUB_B_LO   = 6;
  localparam int FAST_RST   = 8;
  localparam int GAIN_ALIGN = 10;
  localparam int ST_RUN     = 0;
  localparam int ST_REC     = 1;
  localparam int ST_DIV_LO  = 2;
  localparam int ST_SLEEP   = 4;
  localparam int COL_FIX_LO = 8;
  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [15:0] GLOBAL_RST  = 16'h0000;
  localparam logic [15:0] GLOBAL_MASK = 16'h05F0;
  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam logic [15:0] ADC_RST     = 16'h5F9C;
  localparam logic [15:0] COL_RST     = 16'h0077;
  localparam logic [15:0] COL_MASK    = 16'hF0FF;
  localparam logic [15:0] GAIN_RST    = 16'h0000;
  // ----------------------------------------
  // Subsampling codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    SUB_FULL     = 2'b00,
    SUB_TWO_TWO  = 2'b01,
    SUB_TWO_SIX  = 2'b10,
    SUB_INVALID  = 2'b11
  } scs_sub_type;
endpackage
`default_nettype wire

// *** logic/scs_capture_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (R1) Bits 5:4 select first record subsampling; code 0 reads every pixel.
// (R2) Code 1 keeps two skips two, code 2 keeps two skips six, 3 unsupported.
// (R3) Bits 7:6 select second record subsampling, same encoding.
// (R4) Software should keep second record unsubsampled for snapshots.
// (R5) Bit 8 selects accelerated frame reset for flashed acquisitions.
// (R6) Bit 10 set defers gain updates to frame boundary; clear applies immediately.
// (R7) Status read-only, reset zero: run, record, division, sleep; 15:5 zero.
// (R8) ADC bias register is 16-bit read-write, resets to 0x5F9C.
// (R9) Software should set ADC bias to 0x5F9B for preview/snapshot/low power.
// (R10) ADC bias holds per-record fast and step bias fields.
// (R11) Column amp bias resets 0x0077; two 4-bit fields; bits 11:8 zero.
// (R12) Software should write 0x0073 to column amp bias for preview use.
module scs_capture_regs (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capRunning,
  input  wire logic        capRecord,
  input  wire logic [1:0]  capDivision,
  input  wire logic        capSleep,
  input  wire logic        frameStart,
  output logic      [1:0]  subsampleFirst,
  output logic      [1:0]  subsampleSecond,
  output logic             fastFrameReset,
  output logic             gainFrameAlign,
  output logic             firstConverterFastBias,
  output logic      [3:0]  firstConverterStepBias,
  output logic             secondConverterFastBias,
  output logic      [3:0]  secondConverterStepBias,
  output logic      [3:0]  firstColumnBias,
  output logic      [3:0]  secondColumnBias,
  output logic      [15:0] analogGain
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  logic        access;
  logic        wrAccess;
  logic        mapped;
  logic        wrGain;
  logic [15:0] globalSettings;
  logic [15:0] next_globalSettings;
  logic [15:0] statusWord;
  logic [15:0] next_statusWord;
  logic [15:0] adcBias;
  logic [15:0] next_adcBias;
  logic [15:0] colBias;
  logic [15:0] next_colBias;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [15:0] gainPending;
  logic [15:0] gainActive;

  assign access   = psel && penable && !pready;
  assign wrAccess = access && pwrite;
  assign mapped   = hit(paddr, scs_pkg::IDX_GLOBAL) || hit(paddr, scs_pkg::IDX_STATUS)
                 || hit(paddr, scs_pkg::IDX_ADC) || hit(paddr, scs_pkg::IDX_COL)
                 || hit(paddr, scs_pkg::IDX_SENSE) || hit(paddr, scs_pkg::IDX_GAIN);
  assign wrGain   = wrAccess && hit(paddr, scs_pkg::IDX_GAIN);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_comb begin
    next_globalSettings = globalSettings;
    next_adcBias        = adcBias;
    next_colBias        = colBias;
    if (wrAccess && hit(paddr, scs_pkg::IDX_GLOBAL)) begin
      // Unimplemented lower bits stay zero
      next_globalSettings = merge(globalSettings, pwdata, pstrb) & scs_pkg::GLOBAL_MASK; // R1 R3 R5 R6
    end
    if (wrAccess && hit(paddr, scs_pkg::IDX_ADC)) begin
      next_adcBias = merge(adcBias, pwdata, pstrb); // R8 R10
    end
    if (wrAccess && hit(paddr, scs_pkg::IDX_COL)) begin
      next_colBias = merge(colBias, pwdata, pstrb) & scs_pkg::COL_MASK; // R11
    end
  end

  // Status sampled every cycle; writes to it are refused
  always_comb begin
    next_statusWord = scs_pkg::STATUS_RST; // R7
    next_statusWord[scs_pkg::ST_RUN]                   = capRunning;
    next_statusWord[scs_pkg::ST_REC]                   = capRecord;
    next_statusWord[scs_pkg::ST_DIV_LO +: 2]           = capDivision;
    next_statusWord[scs_pkg::ST_SLEEP]                 = capSleep;
  end

  // ----------------------------------------
  // APB answer, one wait state
  // ----------------------------------------
  always_comb begin
    next_pready  = access;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (access) begin
      next_pslverr = !mapped || (pwrite && hit(paddr, scs_pkg::IDX_STATUS)); // R7
      if (!pwrite) begin
        if (hit(paddr, scs_pkg::IDX_GLOBAL)) next_prdata = {16'h0000, globalSettings};
        if (hit(paddr, scs_pkg::IDX_STATUS)) next_prdata = {16'h0000, statusWord}; // R7
        if (hit(paddr, scs_pkg::IDX_ADC))    next_prdata = {16'h0000, adcBias};
        if (hit(paddr, scs_pkg::IDX_COL))    next_prdata = {16'h0000, colBias};
        if (hit(paddr, scs_pkg::IDX_SENSE))  next_prdata = {16'h0000, gainActive};
        if (hit(paddr, scs_pkg::IDX_GAIN))   next_prdata = {16'h0000, gainPending};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      globalSettings <= scs_pkg::GLOBAL_RST;
      statusWord     <= scs_pkg::STATUS_RST; // R7
      adcBias        <= scs_pkg::ADC_RST; // R8
      colBias        <= scs_pkg::COL_RST; // R11
      prdata         <= 32'h0000_0000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
    end else begin
      globalSettings <= next_globalSettings;
      statusWord     <= next_statusWord;
      adcBias        <= next_adcBias;
      colBias        <= next_colBias;
      prdata         <= next_prdata;
      pready         <= next_pready;
      pslverr        <= next_pslverr;
    end
  end

  // ----------------------------------------
  // Gain update timing
  // ----------------------------------------
  scs_gain_sync scs_gain_sync_inst (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .frameAlign  (globalSettings[scs_pkg::GAIN_ALIGN]),
    .frameStart  (frameStart),
    .gainWrite   (wrGain),
    .gainWdata   (pwdata[15:0]),
    .gainPending (gainPending),
    .gainActive  (gainActive)
  );

  // ----------------------------------------
  // Control outputs, registered
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      subsampleFirst          <= scs_pkg::GLOBAL_RST[scs_pkg::SUB_A_LO +: 2];
      subsampleSecond         <= scs_pkg::GLOBAL_RST[scs_pkg::SUB_B_LO +: 2];
      fastFrameReset          <= scs_pkg::GLOBAL_RST[scs_pkg::FAST_RST];
      gainFrameAlign          <= scs_pkg::GLOBAL_RST[scs_pkg::GAIN_ALIGN];
      firstConverterFastBias  <= scs_pkg::ADC_RST[0];
      firstConverterStepBias  <= scs_pkg::ADC_RST[4:1];
      secondConverterFastBias <= scs_pkg::ADC_RST[5];
      secondConverterStepBias <= scs_pkg::ADC_RST[9:6];
      firstColumnBias         <= scs_pkg::COL_RST[3:0];
      secondColumnBias        <= scs_pkg::COL_RST[7:4];
      analogGain              <= scs_pkg::GAIN_RST;
    end else begin
      // Unsupported code 3 falls back to full readout
      subsampleFirst  <= (next_globalSettings[scs_pkg::SUB_A_LO +: 2] == scs_pkg::SUB_INVALID)
                         ? scs_pkg::SUB_FULL : next_globalSettings[scs_pkg::SUB_A_LO +: 2]; // R1 R2
      subsampleSecond <= (next_globalSettings[scs_pkg::SUB_B_LO +: 2] == scs_pkg::SUB_INVALID)
                         ? scs_pkg::SUB_FULL : next_globalSettings[scs_pkg::SUB_B_LO +: 2]; // R3
      fastFrameReset          <= next_globalSettings[scs_pkg::FAST_RST]; // R5
      gainFrameAlign          <= next_globalSettings[scs_pkg::GAIN_ALIGN]; // R6
      firstConverterFastBias  <= next_adcBias[0]; // R10
      firstConverterStepBias  <= next_adcBias[4:1];
      secondConverterFastBias <= next_adcBias[5];
      secondConverterStepBias <= next_adcBias[9:6];
      firstColumnBias         <= next_colBias[3:0]; // R11
      secondColumnBias        <= next_colBias[7:4];
      analogGain              <= gainActive;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_status_hi_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      statusWord[15:5] == 11'h000;
  endproperty
  a_status_hi_zero: assert property (p_status_hi_zero) // R7
    else $error("status upper bits not zero");

  property p_status_follow;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> statusWord[4:0] == {$past(capSleep), $past(capDivision), $past(capRecord), $past(capRunning)};
  endproperty
  a_status_follow: assert property (p_status_follow) // R7
    else $error("status fields stale");

  property p_status_refused;
    @(posedge ref_clk) disable iff (!rst_n)
      wrAccess && hit(paddr, scs_pkg::IDX_STATUS) |=> pready && pslverr;
  endproperty
  a_status_refused: assert property (p_status_refused) // R7
    else $error("status write not refused");

  property p_col_fixed;
    @(posedge ref_clk) disable iff (!rst_n)
      colBias[scs_pkg::COL_FIX_LO +: 4] == 4'h0;
  endproperty
  a_col_fixed: assert property (p_col_fixed) // R11
    else $error("column fixed field nonzero");

  property p_adc_write;
    @(posedge ref_clk) disable iff (!rst_n)
      wrAccess && hit(paddr, scs_pkg::IDX_ADC) && pstrb == 4'hF |=> adcBias == $past(pwdata[15:0]);
  endproperty
  a_adc_write: assert property (p_adc_write) // R8
    else $error("adc bias write lost");

  property p_sub_full;
    @(posedge ref_clk) disable iff (!rst_n)
      globalSettings[scs_pkg::SUB_A_LO +: 2] == scs_pkg::SUB_FULL |-> subsampleFirst == scs_pkg::SUB_FULL;
  endproperty
  a_sub_full: assert property (p_sub_full) // R1
    else $error("first subsampling not full");

  property p_sub_first;
    @(posedge ref_clk) disable iff (!rst_n)
      subsampleFirst != scs_pkg::SUB_INVALID;
  endproperty
  a_sub_first: assert property (p_sub_first) // R2
    else $error("unsupported subsampling driven");

  property p_sub_second;
    @(posedge ref_clk) disable iff (!rst_n)
      globalSettings[scs_pkg::SUB_B_LO +: 2] == 2'b01 |-> subsampleSecond == 2'b01;
  endproperty
  a_sub_second: assert property (p_sub_second) // R3
    else $error("second subsampling wrong");

  property p_fast;
    @(posedge ref_clk) disable iff (!rst_n)
      fastFrameReset == globalSettings[scs_pkg::FAST_RST];
  endproperty
  a_fast: assert property (p_fast) // R5
    else $error("fast reset mismatch");

  property p_align;
    @(posedge ref_clk) disable iff (!rst_n)
      gainFrameAlign == globalSettings[scs_pkg::GAIN_ALIGN];
  endproperty
  a_align: assert property (p_align) // R6
    else $error("gain align mismatch");

  property p_adc_fields;
    @(posedge ref_clk) disable iff (!rst_n)
      {secondConverterStepBias, secondConverterFastBias, firstConverterStepBias, firstConverterFastBias}
        == adcBias[9:0];
  endproperty
  a_adc_fields: assert property (p_adc_fields) // R10
    else $error("converter bias fields mismatch");

  property p_col_fields;
    @(posedge ref_clk) disable iff (!rst_n)
      {secondColumnBias, firstColumnBias} == colBias[7:0];
  endproperty
  a_col_fields: assert property (p_col_fields) // R11
    else $error("column bias fields mismatch");

  property p_gain_out;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> analogGain == $past(gainActive);
  endproperty
  a_gain_out: assert property (p_gain_out) // R6
    else $error("analog gain output stale");

  property p_ready;
    @(posedge ref_clk) disable iff (!rst_n)
      psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("answer timing wrong");

  // Reset checks carry no disable, they must hold while reset is low
  property p_status_reset;
    @(posedge ref_clk)
      !rst_n |=> statusWord == scs_pkg::STATUS_RST;
  endproperty
  a_status_reset: assert property (p_status_reset) // R7
    else $error("status reset value wrong");

  property p_adc_reset;
    @(posedge ref_clk)
      !rst_n |=> adcBias == scs_pkg::ADC_RST;
  endproperty
  a_adc_reset: assert property (p_adc_reset) // R8
    else $error("adc bias reset value wrong");

  property p_col_reset;
    @(posedge ref_clk)
      !rst_n |=> colBias == scs_pkg::COL_RST;
  endproperty
  a_col_reset: assert property (p_col_reset) // R11
    else $error("column bias reset value wrong");
endmodule // scs_capture_regs
`default_nettype wire

// *** logic/scs_gain_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module scs_gain_sync (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        frameAlign,
  input  wire logic        frameStart,
  input  wire logic        gainWrite,
  input  wire logic [15:0] gainWdata,
  output logic      [15:0] gainPending,
  output logic      [15:0] gainActive
);
  logic [15:0] next_gainPending;
  logic [15:0] next_gainActive;
  logic        held;
  logic        next_held;

  always_comb begin
    next_gainPending = gainPending;
    next_gainActive  = gainActive;
    next_held        = held;
    if (gainWrite) begin
      next_gainPending = gainWdata;
      if (!frameAlign) begin
        next_gainActive = gainWdata; // R6
        next_held       = 1'b0;
      end else begin
        next_held = 1'b1;
      end
    end
    // Write in the boundary cycle waits for the next frame
    if (frameAlign && held && frameStart && !gainWrite) begin
      next_gainActive = gainPending; // R6
      next_held       = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gainPending <= scs_pkg::GAIN_RST;
      gainActive  <= scs_pkg::GAIN_RST;
      held        <= 1'b0;
    end else begin
      gainPending <= next_gainPending;
      gainActive  <= next_gainActive;
      held        <= next_held;
    end
  end

  property p_immediate;
    @(posedge ref_clk) disable iff (!rst_n)
      gainWrite && !frameAlign |=> gainActive == $past(gainWdata);
  endproperty
  a_immediate: assert property (p_immediate) // R6
    else $error("gain not applied at once");

  property p_deferred;
    @(posedge ref_clk) disable iff (!rst_n)
      gainWrite && frameAlign |=> $stable(gainActive);
  endproperty
  a_deferred: assert property (p_deferred) // R6
    else $error("gain applied before frame boundary");
endmodule // scs_gain_sync
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin nCompared++; if ((got) !== (exp)) begin failCount++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_top;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        capRunning  = 1'b0;
  logic        capRecord   = 1'b0;
  logic [1:0]  capDivision = 2'h0;
  logic        capSleep    = 1'b0;
  logic        frameStart  = 1'b0;
  logic [1:0]  subFirst, subSecond;
  logic        fastReset, gainAlign, fastA, fastB;
  logic [3:0]  stepA, stepB, colA, colB;
  logic [15:0] gain;
  logic [15:0] seed = 16'h7489;
  logic [15:0] v;
  logic [33:0] expQ[$];
  logic [33:0] e;
  int          failCount  = 0;
  int          nCompared  = 0;
  int          cycles     = 0;

  always #12.5 ref_clk = ~ref_clk;

  scs_capture_regs scs_capture_regs_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capRunning(capRunning), .capRecord(capRecord),
    .capDivision(capDivision), .capSleep(capSleep), .frameStart(frameStart),
    .subsampleFirst(subFirst), .subsampleSecond(subSecond), .fastFrameReset(fastReset),
    .gainFrameAlign(gainAlign), .firstConverterFastBias(fastA),
    .firstConverterStepBias(stepA), .secondConverterFastBias(fastB),
    .secondConverterStepBias(stepB), .firstColumnBias(colA), .secondColumnBias(colB),
    .analogGain(gain)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Idle cycle first, so a release never meets the next setup in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic err, input logic [15:0] rexp);
    @(posedge ref_clk);
    expQ.push_back({~w & ~err, err, 16'h0000, rexp});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Answer monitor
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (pready === 1'b1) begin
      if (expQ.size() == 0) `CHK("unexpected answer", 1'b0, 1'b1)
      else begin
        e = expQ.pop_front();
        `CHK("pslverr", e[32], pslverr)
        if (e[33]) `CHK("prdata", e[31:0], prdata)
      end
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failCount++;
      final_report();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h018, 16'h0000, 1'b0, 16'h0000);
    apb(1'b0, 12'h040, 16'h0000, 1'b0, 16'h5F9C);
    apb(1'b0, 12'h044, 16'h0000, 1'b0, 16'h0077);
    apb(1'b0, 12'h014, 16'h0000, 1'b0, 16'h0000);
    `CHK("step bias reset", 8'hEE, {stepA, stepB})
    `CHK("column bias reset", 8'h77, {colA, colB})
    for (int c = 0; c < 4; c++) begin
      v = 16'((c << 4) | ((3 - c) << 6) | ((c % 2) << 8) | ((c / 2) << 10));
      apb(1'b1, 12'h014, v, 1'b0, 16'h0000);
      apb(1'b0, 12'h014, 16'h0000, 1'b0, v & scs_pkg::GLOBAL_MASK);
      settle();
      `CHK("first subsample", (c == 3) ? 2'h0 : 2'(c), subFirst)
      `CHK("second subsample", (c == 0) ? 2'h0 : 2'(3 - c), subSecond)
      `CHK("fast frame reset", 1'(c % 2), fastReset)
      `CHK("gain align", 1'(c / 2), gainAlign)
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge ref_clk);
      {capSleep, capDivision, capRecord, capRunning} <= {seed[4], 2'(seed[3:2] % 3), seed[1:0]};
      @(posedge ref_clk);
      v = {11'h000, seed[4], 2'(seed[3:2] % 3), seed[1:0]};
      apb(1'b0, 12'h018, 16'h0000, 1'b0, v);
      apb(1'b1, 12'h018, seed, 1'b1, 16'h0000);
      apb(1'b0, 12'h018, 16'h0000, 1'b0, v);
    end
    apb(1'b0, 12'h030, 16'h0000, 1'b1, 16'h0000);
    apb(1'b1, 12'h042, 16'h1234, 1'b1, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 16'h5F9B : seed;
      apb(1'b1, 12'h040, v, 1'b0, 16'h0000);
      apb(1'b0, 12'h040, 16'h0000, 1'b0, v);
      settle();
      `CHK("adc bias fields", {v[0], v[4:1], v[5], v[9:6]}, {fastA, stepA, fastB, stepB})
      v = (i == 0) ? 16'h0073 : seed;
      apb(1'b1, 12'h044, v, 1'b0, 16'h0000);
      apb(1'b0, 12'h044, 16'h0000, 1'b0, v & scs_pkg::COL_MASK);
      settle();
      `CHK("column bias fields", v[7:0], {colB, colA})
    end
    seed = lfsr(seed);
    apb(1'b1, 12'h084, seed, 1'b0, 16'h0000);
    settle();
    `CHK("gain held", 16'h0000, gain)
    @(posedge ref_clk);
    frameStart <= 1'b1;
    @(posedge ref_clk);
    frameStart <= 1'b0;
    settle();
    `CHK("gain at frame", seed, gain)
    apb(1'b1, 12'h014, 16'h0000, 1'b0, 16'h0000);
    settle();
    `CHK("second subsample snapshot", 2'h0, subSecond)
    seed = lfsr(seed);
    apb(1'b1, 12'h084, seed, 1'b0, 16'h0000);
    settle();
    `CHK("gain immediate", seed, gain)
    apb(1'b0, 12'h080, 16'h0000, 1'b0, seed);
    settle();
    `CHK("queue drained", 0, expQ.size())
    final_report();
  end
endmodule // tb_top
`default_nettype wire
